// File: pkg/enclosure_link_pkg.sv
package enclosure_link_pkg;
	// Core clock rate
	localparam int CLK_MHZ = 125;

	// Link timing, in printed units
	localparam int T_SETTLE_NS  = 4000;
	localparam int T_RESENSE_NS = 7000;
	localparam int T_SETUP_NS   = 3000;
	localparam int T_PHASE_US   = 100;
	localparam int T_FIRST_MS   = 1;
	localparam int T_REARM_MS   = 20;
	localparam int T_ACK_MS     = 1000;

	// Least times round up, timeouts are exact multiples of the period
	localparam int T_SETTLE_CYC  = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RESENSE_CYC = (T_RESENSE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_PHASE_DEF   = T_PHASE_US * CLK_MHZ;
	localparam int T_FIRST_DEF   = T_FIRST_MS * 1000 * CLK_MHZ;
	localparam int T_REARM_DEF   = T_REARM_MS * 1000 * CLK_MHZ;
	localparam int T_ACK_DEF     = T_ACK_MS * 1000 * CLK_MHZ;
	localparam int TMR_W         = 27;

	// Multiplexed slot line positions
	localparam int LINE_W  = 7;
	localparam int DATA_W  = 4;
	localparam int LN_ACK  = 4;
	localparam int LN_RD   = 5;
	localparam int LN_WR   = 6;

	// Command phase layout
	localparam int CMD_BYTES    = 4;
	localparam int CMD_SEND_BIT = 0;
	localparam int LEN_W        = 16;
	localparam int CNT_W        = 17;

	// Unmated-triggered request, values arbitrary
	localparam logic [7:0]       UNMATED_PAGE = 8'h01;
	localparam logic [LEN_W-1:0] UNMATED_LEN  = 16'h0008;

	typedef enum logic [2:0] {
		STAT_OK          = 3'h0,
		STAT_UNAVAILABLE = 3'h1,
		STAT_REFUSED     = 3'h2,
		STAT_TIMEOUT     = 3'h3,
		STAT_LEGACY_PAR  = 3'h4,
		STAT_LEGACY_NONE = 3'h5
	} status_t;
endpackage

// File: rtl/byte_buffer2.sv
`timescale 1ns/1ps
module byte_buffer2 #(
	parameter int WIDTH = 8
)(
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wp_q;
	logic             rp_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	// Two entries so one word can wait while the next is being sampled
	assign in_ready_o  = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o  = mem_q[rp_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			wp_q  <= wp_q ^ push;
			rp_q  <= rp_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// File: rtl/enclosure_nibble_link.sv
`timescale 1ns/1ps
// How it works
// RL1 - Start on a pass-through diagnostic request or when both mate senses read un-mated.
// RL2 - After asserting link request, wait 4 us before judging the lines.
// RL3 - Order is discovery, four command bytes, one data phase, then request negation.
// RL4 - After negating link request, wait 7 us before sampling slot ID.
// RL5 - Keep link request negated at least 20 ms before asserting again.
// RL6 - Enclosure treats request negation as abort of the whole transaction.
// RL7 - Enclosure drives acknowledge, frees strobe lines, complements ID within 1 us.
// RL8 - Uncomplemented ID means non-compliant; other unexpected value means legacy parallel status.
// RL9 - Unchanged ID after 4 us means legacy without parallel status, check condition.
// RL10 - Enclosure acknowledges only one requesting slot at a time.
// RL11 - No acknowledge within one second: services unavailable, negate request.
// RL12 - On acknowledge assert both strobes; no negation within 100 us means legacy.
// RL13 - Negate both strobes; strobes failing to negate report refused-transfer timeout.
// RL14 - Each handshake is timed against 100 us; expiry reports check condition.
// RL15 - First data strobe after command phase is timed against 1 ms.
// RL16 - Enclosure may drop an idle device after 100 ms until re-request.
// RL17 - Legacy mode starts no nibble transfers and reports sampled parallel status.
// RL18 - Legacy enclosure restores slot ID under 4 us after request negation.
// RL19 - On a legacy backplane the device behaves purely as a legacy device.
// RL20 - Write handshake: nibble, 3 us setup, strobe, acknowledge, strobe off, ack off.
// RL21 - After the last write before a read phase, release the data lines.
// RL22 - Bytes travel high nibble first, nibble MSB on data line 3.
// RL23 - The command phase carries exactly four bytes clocked by the write strobe.
// RL24 - Read handshake: strobe, acknowledge, wait 3 us, sample, strobe off, ack off.
// RL25 - Send bit 1 selects write strobe data phase, 0 selects read strobe.
// RL26 - Data block bytes move in ascending index order.
module enclosure_nibble_link
	import enclosure_link_pkg::*;
#(
	parameter logic [TMR_W-1:0] T_PHASE_CYC = TMR_W'(T_PHASE_DEF),
	parameter logic [TMR_W-1:0] T_FIRST_CYC = TMR_W'(T_FIRST_DEF),
	parameter logic [TMR_W-1:0] T_REARM_CYC = TMR_W'(T_REARM_DEF),
	parameter logic [TMR_W-1:0] T_ACK_CYC   = TMR_W'(T_ACK_DEF)
)(
	input  wire logic                                core_clk_i,
	input  wire logic                                rst_i,
	input  wire logic                                cmd_valid_i,
	output logic                                     cmd_ready_o,
	input  wire logic [7:0]                          cmd_page_i,
	input  wire logic                                cmd_send_i,
	input  wire logic [enclosure_link_pkg::LEN_W-1:0] cmd_len_i,
	input  wire logic [1:0]                          mate_open_i,
	input  wire logic                                wr_valid_i,
	output logic                                     wr_ready_o,
	input  wire logic [7:0]                          wr_data_i,
	output logic                                     rd_valid_o,
	input  wire logic                                rd_ready_i,
	output logic      [7:0]                          rd_data_o,
	output logic                                     link_request_n_o,
	input  wire logic [enclosure_link_pkg::LINE_W-1:0] slot_line_i,
	output logic      [enclosure_link_pkg::LINE_W-1:0] slot_line_o,
	output logic      [enclosure_link_pkg::LINE_W-1:0] slot_line_oe_o,
	output logic                                     done_o,
	output enclosure_link_pkg::status_t              status_o,
	output logic      [enclosure_link_pkg::LINE_W-1:0] legacy_status_o,
	output logic                                     legacy_mode_o,
	output logic      [enclosure_link_pkg::LINE_W-1:0] slot_id_o,
	output logic                                     busy_o
);
	import enclosure_link_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_SETTLE = 4'h1,
		S_ACK    = 4'h2,
		S_BOTH   = 4'h3,
		S_DREL   = 4'h4,
		S_LOAD   = 4'h5,
		S_WSET   = 4'h6,
		S_WSTB   = 4'h7,
		S_WREL   = 4'h8,
		S_RSTB   = 4'h9,
		S_RHOLD  = 4'hA,
		S_RREL   = 4'hB,
		S_END    = 4'hC,
		S_REARM  = 4'hD
	} state_t;

	state_t            state_q, state_d;
	status_t           stat_d;
	logic              fin_d;
	logic [LINE_W-1:0] line_s;
	logic [1:0]        mate_s;
	logic              unmated_q;
	logic              start_un;
	logic [TMR_W-1:0]  tmr_q;
	logic [TMR_W-1:0]  lim;
	logic [LINE_W-1:0] snap_q;
	logic              send_q;
	logic [LEN_W-1:0]  len_q;
	logic [7:0]        page_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  total;
	logic              nib_hi_q;
	logic [7:0]        byte_q;
	logic              drive_q;
	logic              legacy_q;
	logic [7:0]        cmd_b [CMD_BYTES];
	logic [3:0]        nib_out;
	logic              wr_on;
	logic              rd_on;
	logic              ack_low;
	logic              in_data;
	logic              buf_ready;
	logic              buf_push;
	logic              hs_done;

	line_sync #(.WIDTH(LINE_W)) u_line_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (slot_line_i),
		.sync_o     (line_s)
	);

	line_sync #(.WIDTH(2)) u_mate_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (mate_open_i),
		.sync_o     (mate_s)
	);

	// Command bytes; length is zero for an inbound transfer
	assign cmd_b[0] = page_q;
	assign cmd_b[1] = {7'h00, send_q};
	assign cmd_b[2] = send_q ? len_q[15:8] : 8'h00;
	assign cmd_b[3] = send_q ? len_q[7:0] : 8'h00;

	assign ack_low  = !line_s[LN_ACK];
	assign in_data  = (cnt_q >= CNT_W'(CMD_BYTES));
	assign total    = CNT_W'(CMD_BYTES) + {1'b0, len_q};
	assign start_un = (&mate_s) && !unmated_q;
	// First data strobe gets the long limit, all others the phase limit
	assign lim      = (cnt_q == CNT_W'(CMD_BYTES) && nib_hi_q) ? T_FIRST_CYC : T_PHASE_CYC; // [RL15]
	assign hs_done  = (tmr_q >= TMR_W'(T_SETUP_CYC - 1));

	// Next state; every failure path ends by negating the request
	always_comb begin
		state_d = state_q;
		stat_d  = STAT_OK;
		fin_d   = 1'b0;
		case (state_q)
			S_IDLE: begin
				if ((cmd_valid_i || start_un)) begin // [RL1]
					state_d = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (tmr_q >= TMR_W'(T_SETTLE_CYC - 1)) begin // [RL2]
					fin_d = 1'b1;
					state_d = S_END;
					if (legacy_q) begin
						stat_d = STAT_LEGACY_PAR; // [RL17] [RL19]
					end else if (line_s == snap_q) begin
						stat_d = STAT_LEGACY_NONE; // [RL9]
					end else if (line_s[3:0] == ~snap_q[3:0] && line_s[LN_WR] && line_s[LN_RD]) begin
						fin_d = 1'b0;
						state_d = S_ACK;
					end else begin
						stat_d = STAT_LEGACY_PAR; // [RL8]
					end
				end
			end
			S_ACK: begin
				if (ack_low) begin
					state_d = S_BOTH;
				end else if (tmr_q >= T_ACK_CYC - 1'b1) begin // [RL11]
					fin_d = 1'b1;
					stat_d = STAT_UNAVAILABLE;
					state_d = S_END;
				end
			end
			S_BOTH: begin
				if (!ack_low) begin
					state_d = S_DREL;
				end else if (tmr_q >= T_PHASE_CYC - 1'b1) begin // [RL12]
					fin_d = 1'b1;
					stat_d = STAT_LEGACY_PAR;
					state_d = S_END;
				end
			end
			S_DREL: begin
				if (line_s[LN_WR] && line_s[LN_RD]) begin
					state_d = S_LOAD;
				end else if (tmr_q >= T_PHASE_CYC - 1'b1) begin // [RL13]
					fin_d = 1'b1;
					stat_d = STAT_REFUSED;
					state_d = S_END;
				end
			end
			S_LOAD: begin
				if (!in_data) begin
					state_d = S_WSET; // [RL23]
				end else if (cnt_q == total) begin // [RL3]
					fin_d = 1'b1;
					state_d = S_END;
				end else if (send_q) begin
					if (wr_valid_i) begin
						state_d = S_WSET; // [RL25]
					end
				end else if (buf_ready) begin
					state_d = S_RSTB; // [RL25]
				end
			end
			S_WSET: begin
				if (hs_done) begin
					state_d = S_WSTB; // [RL20]
				end
			end
			S_WSTB, S_RSTB: begin
				if (ack_low) begin
					state_d = (state_q == S_WSTB) ? S_WREL : S_RHOLD;
				end else if (tmr_q >= lim - 1'b1) begin // [RL14] [RL15]
					fin_d = 1'b1;
					stat_d = STAT_TIMEOUT;
					state_d = S_END;
				end
			end
			S_RHOLD: begin
				if (hs_done) begin
					state_d = S_RREL; // [RL24]
				end
			end
			S_WREL, S_RREL: begin
				if (!ack_low) begin
					if (nib_hi_q) begin
						state_d = (state_q == S_WREL) ? S_WSET : S_RSTB;
					end else begin
						state_d = S_LOAD;
					end
				end else if (tmr_q >= T_PHASE_CYC - 1'b1) begin // [RL14]
					fin_d = 1'b1;
					stat_d = STAT_TIMEOUT;
					state_d = S_END;
				end
			end
			S_END: begin
				if (tmr_q >= TMR_W'(T_RESENSE_CYC - 1)) begin // [RL4]
					state_d = S_REARM;
				end
			end
			S_REARM: begin
				if (tmr_q >= T_REARM_CYC - 1'b1) begin // [RL5]
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	// State and phase timer; the timer runs on from END into REARM
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			tmr_q   <= '0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q && state_d != S_REARM) begin
				tmr_q <= '0;
			end else if (tmr_q != {TMR_W{1'b1}}) begin
				tmr_q <= tmr_q + 1'b1;
			end
		end
	end

	// Request capture; unmated start uses a fixed inbound request
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			unmated_q <= 1'b1; // Syncs reset high; avoids a false unmated start
			snap_q    <= '0;
			send_q    <= 1'b0;
			len_q     <= '0;
			page_q    <= 8'h00;
		end else begin
			unmated_q <= &mate_s;
			if (state_q == S_IDLE) begin
				snap_q <= line_s;
				if (cmd_valid_i) begin
					send_q <= cmd_send_i;
					len_q  <= cmd_len_i;
					page_q <= cmd_page_i;
				end else if (start_un) begin
					send_q <= 1'b0;
					len_q  <= UNMATED_LEN;
					page_q <= UNMATED_PAGE;
				end
			end
		end
	end

	// Byte and nibble sequencing
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q    <= '0;
			nib_hi_q <= 1'b1;
			byte_q   <= 8'h00;
			drive_q  <= 1'b0;
		end else begin
			if (state_q == S_IDLE) begin
				cnt_q    <= '0;
				nib_hi_q <= 1'b1;
			end
			if (state_q == S_LOAD && state_d == S_WSET) begin
				byte_q  <= in_data ? wr_data_i : cmd_b[cnt_q[1:0]];
				drive_q <= 1'b1;
			end
			if (state_q == S_RHOLD && hs_done && nib_hi_q) begin
				byte_q[7:4] <= line_s[3:0]; // [RL22]
			end
			if (state_q == S_WSTB && ack_low && !nib_hi_q &&
			    cnt_q == CNT_W'(CMD_BYTES - 1) && !send_q) begin
				drive_q <= 1'b0; // [RL21]
			end
			if (state_d == S_END) begin
				drive_q <= 1'b0;
			end
			if ((state_q == S_WREL || state_q == S_RREL) && !ack_low) begin
				nib_hi_q <= !nib_hi_q;
				if (!nib_hi_q) begin
					cnt_q <= cnt_q + 1'b1; // [RL26]
				end
			end
		end
	end

	// Result reporting and sticky legacy mode
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			done_o          <= 1'b0;
			status_o        <= STAT_OK;
			legacy_status_o <= '0;
			legacy_q        <= 1'b0;
			slot_id_o       <= '0;
		end else begin
			done_o <= fin_d;
			if (fin_d) begin
				status_o <= stat_d;
				if (stat_d == STAT_LEGACY_PAR) begin
					legacy_status_o <= line_s; // [RL17]
				end
				if (stat_d == STAT_LEGACY_PAR || stat_d == STAT_LEGACY_NONE) begin
					legacy_q <= 1'b1; // [RL19]
				end
			end
			if (state_q == S_END && state_d == S_REARM) begin
				slot_id_o <= line_s; // [RL4]
			end
		end
	end

	// Inbound bytes wait here so a stalled reader loses nothing
	assign buf_push = (state_q == S_RHOLD) && hs_done && !nib_hi_q;
	byte_buffer2 #(.WIDTH(8)) u_rd_buf (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (buf_push),
		.in_ready_o  (buf_ready),
		.in_data_i   ({byte_q[7:4], line_s[3:0]}),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	// Open-drain pins: only ever pull low, a released line floats high
	assign nib_out = nib_hi_q ? byte_q[7:4] : byte_q[3:0]; // [RL22]
	assign wr_on   = (state_q == S_BOTH) || (state_q == S_WSTB); // [RL12] [RL20]
	assign rd_on   = (state_q == S_BOTH) || (state_q == S_RSTB) || (state_q == S_RHOLD);
	assign slot_line_o              = '0;
	assign slot_line_oe_o[3:0]      = drive_q ? ~nib_out : 4'h0;
	assign slot_line_oe_o[LN_ACK]   = 1'b0;
	assign slot_line_oe_o[LN_RD]    = rd_on;
	assign slot_line_oe_o[LN_WR]    = wr_on;
	assign link_request_n_o = (state_q == S_IDLE) || (state_q == S_END) || (state_q == S_REARM);
	assign cmd_ready_o      = (state_q == S_IDLE);
	assign wr_ready_o       = (state_q == S_LOAD) && in_data && send_q && (cnt_q != total);
	assign legacy_mode_o    = legacy_q;
	assign busy_o           = !cmd_ready_o;

	// Helper counters seen only by the checks below
	logic [TMR_W-1:0] hi_cnt;
	logic [TMR_W-1:0] lo_cnt;
	logic [TMR_W-1:0] dat_cnt;
	logic [TMR_W-1:0] ack_cnt;
	logic [3:0]       oe_last;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hi_cnt  <= {TMR_W{1'b1}};
			lo_cnt  <= '0;
			dat_cnt <= '0;
			ack_cnt <= '0;
			oe_last <= 4'h0;
		end else begin
			oe_last <= slot_line_oe_o[3:0];
			hi_cnt  <= !link_request_n_o ? '0 : (&hi_cnt ? hi_cnt : hi_cnt + 1'b1);
			lo_cnt  <= link_request_n_o ? '0 : (&lo_cnt ? lo_cnt : lo_cnt + 1'b1);
			dat_cnt <= (slot_line_oe_o[3:0] != oe_last) ? '0 : (&dat_cnt ? dat_cnt : dat_cnt + 1'b1);
			ack_cnt <= !ack_low ? '0 : (&ack_cnt ? ack_cnt : ack_cnt + 1'b1);
		end
	end

	a_req_settle: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL2]
		(state_q == S_SETTLE && state_d == S_ACK) |-> lo_cnt >= TMR_W'(T_SETTLE_CYC - 1))
		else $error("lines judged too soon after request");
	a_resense_wait: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL4]
		(state_q == S_END && state_d == S_REARM) |=> $past(hi_cnt) >= TMR_W'(T_RESENSE_CYC - 1))
		else $error("slot id sampled too soon");
	a_rearm_gap: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL5]
		$fell(link_request_n_o) |-> $past(hi_cnt) >= T_REARM_CYC - 1'b1)
		else $error("link request reasserted too soon");
	a_wr_setup: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL20]
		($rose(wr_on) && !rd_on) |-> dat_cnt >= TMR_W'(T_SETUP_CYC - 1))
		else $error("write strobe before data setup");
	a_rd_sample: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL24]
		buf_push |-> (ack_cnt >= TMR_W'(T_SETUP_CYC - 1)) ##1 !rd_on)
		else $error("read sample before hold time");
	a_both_strobes: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL12]
		(state_q == S_ACK && ack_low) |=> (wr_on && rd_on))
		else $error("strobes not raised together on acknowledge");
	a_release_read: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL21]
		rd_on |-> slot_line_oe_o[3:0] == 4'h0)
		else $error("data lines driven during read");
	a_legacy_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL17]
		$past(legacy_q) |-> !wr_on && !rd_on)
		else $error("strobe driven in legacy mode");
	a_ack_timeout: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL11]
		(state_q == S_ACK && !ack_low && tmr_q >= T_ACK_CYC - 1'b1) |=> link_request_n_o && done_o)
		else $error("request held after acknowledge timeout");
	a_fail_release: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL13]
		(fin_d && stat_d == STAT_REFUSED) |=> link_request_n_o && !wr_on && !rd_on)
		else $error("refused transfer left request asserted");
endmodule

// File: rtl/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	// Two flops per bit; the first is read only by the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge core_clk_i) begin
			if (rst_i) begin
				meta_q <= 1'b1;
				sync_q <= 1'b1;
			end else begin
				meta_q <= async_i[i];
				sync_q <= meta_q;
			end
		end
		assign sync_o[i] = sync_q;
	end
endmodule

// File: tb/enclosure_model.sv
`timescale 1ns/1ps
// Behavioural enclosure processor; the lines are open drain with backplane pull-ups
module enclosure_model #(
	parameter logic [6:0] SLOT_ID = 7'h2A,
	parameter logic [6:0] PAR_VAL = 7'h55
)(
	input  wire logic       link_request_n_i,
	input  wire logic [6:0] dev_oe_i,
	input  wire logic [1:0] mode_i,
	output logic      [6:0] line_o
);
	logic [6:0] pull;
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];
	int         dly_ns = 200;

	// A line reads low whenever either party pulls it
	assign line_o = ~(dev_oe_i | pull);

	// Mode 0 full, 1 legacy with status, 2 legacy plain, 3 never acknowledges
	// No idle timeout: a slow device is always answered
	initial begin
		pull = ~SLOT_ID;
		forever begin
			wait (link_request_n_i === 1'b0);
			fork
				session();
				wait (link_request_n_i === 1'b1);
			join_any
			disable fork;
			#500 pull = ~SLOT_ID;
		end
	end

	// One request: discovery, then answer strobes until the request drops
	task automatic session();
		logic [7:0] b;
		logic       hi;
		hi = 1'b1;
		b = 8'h00;
		#500;
		if (mode_i == 2'd1) pull = ~PAR_VAL;
		if (mode_i == 2'd1 || mode_i == 2'd2) wait (1'b0);
		pull = {3'b000, SLOT_ID[3:0]};
		if (mode_i == 2'd3) wait (1'b0);
		#(dly_ns) pull[4] = 1'b1;
		wait (line_o[6:5] == 2'b00);
		#1000 pull = '0;
		wait (line_o[6:5] == 2'b11);
		forever begin
			wait (line_o[6:5] != 2'b11);
			if (!line_o[6]) begin
				b = {b[3:0], line_o[3:0]};
				if (!hi) rx_q.push_back(b);
				#(dly_ns) pull[4] = 1'b1;
				wait (line_o[6]);
				#100 pull[4] = 1'b0;
			end else begin
				if (hi) b = (tx_q.size() != 0) ? tx_q.pop_front() : 8'hFF;
				pull[3:0] = hi ? ~b[7:4] : ~b[3:0];
				#(dly_ns) pull[4] = 1'b1;
				wait (line_o[5]);
				pull = '0;
			end
			hi = !hi;
		end
	endtask
endmodule

// File: tb/enclosure_nibble_link_test.sv
`timescale 1ns/1ps
module enclosure_nibble_link_test;
	import enclosure_link_pkg::*;
	localparam logic [6:0] SLOT_ID = 7'h2A;
	localparam int         REARM   = 2000;
	logic        core_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_send_i = 1'b0;
	logic [7:0]  cmd_page_i = 8'h00, wr_data_i = 8'h00;
	logic [15:0] cmd_len_i = 16'h0000;
	logic [1:0]  mate_open_i = 2'b00, mode = 2'b00;
	logic        wr_valid_i = 1'b0, rd_ready_i = 1'b1, stall = 1'b0;
	logic        cmd_ready_o, wr_ready_o, rd_valid_o, link_request_n_o, done_o;
	logic        legacy_mode_o, busy_o;
	logic [7:0]  rd_data_o;
	logic [6:0]  slot_line_i, slot_line_o, slot_line_oe_o, legacy_status_o, slot_id_o;
	status_t     status_o;
	int          errors = 0, samples_checked = 0, cyc = 0;
	logic [7:0]  wr_q[$], rd_q[$];
	realtime     t_fall = 0, t_rise = 0;

	// Short timers keep the run brief; every expectation uses these values
	enclosure_nibble_link #(.T_PHASE_CYC(27'd1000), .T_FIRST_CYC(27'd2000),
		.T_REARM_CYC(27'd2000), .T_ACK_CYC(27'd4000)) enclosure_nibble_link_i (
		.core_clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_page_i, .cmd_send_i,
		.cmd_len_i, .mate_open_i, .wr_valid_i, .wr_ready_o, .wr_data_i, .rd_valid_o,
		.rd_ready_i, .rd_data_o, .link_request_n_o, .slot_line_i, .slot_line_o,
		.slot_line_oe_o, .done_o, .status_o, .legacy_status_o, .legacy_mode_o,
		.slot_id_o, .busy_o);
	enclosure_model #(.SLOT_ID(SLOT_ID)) enclosure_model_i (.link_request_n_i(link_request_n_o),
		.dev_oe_i(slot_line_oe_o), .mode_i(mode), .line_o(slot_line_i));

	always #4 core_clk_i = ~core_clk_i;

	// Outbound feed and inbound sink, with a receiver that stalls on request
	always @(posedge core_clk_i) begin
		if (wr_valid_i && wr_ready_o) void'(wr_q.pop_front());
		if (rd_valid_o && rd_ready_i) rd_q.push_back(rd_data_o);
		#1;
		wr_valid_i = (wr_q.size() != 0);
		wr_data_i = (wr_q.size() != 0) ? wr_q[0] : 8'h00;
		rd_ready_i = !(stall && cyc[2]);
	end

	// Hang guard, well above the longest expected run
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			errors++;
			complete_run();
		end
	end

	// Request spacing and settle time measured on the wire
	always @(negedge link_request_n_o) begin
		if (t_rise > 0) check(8'($realtime - t_rise >= REARM * 8.0), 8'h01);
		t_fall = $realtime;
	end
	always @(posedge link_request_n_o) t_rise = $realtime;
	always @(posedge (|slot_line_oe_o))
		if (!link_request_n_o) check(8'($realtime - t_fall >= 4000.0), 8'h01);
	always @(posedge slot_line_oe_o[5]) check(8'(slot_line_oe_o[3:0]), 8'h00);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmp_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
		check(8'(got.size()), 8'(exp.size()));
		foreach (exp[i]) check(got[i], exp[i]);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic do_reset();
		rst_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		t_rise = 0;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	task automatic start(input logic [7:0] pg, input logic snd, input logic [15:0] ln);
		cmd_page_i = pg;
		cmd_send_i = snd;
		cmd_len_i = ln;
		cmd_valid_i = 1'b1;
		do @(posedge core_clk_i); while (cmd_ready_o !== 1'b1);
		#1 cmd_valid_i = 1'b0;
	endtask

	// Waits for the end pulse only, at most 30000 cycles; idle() waits out the rearm time
	task automatic wait_done();
		int n;
		n = 0;
		while (done_o !== 1'b1 && n < 30000) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		check(8'(done_o), 8'h01);
	endtask

	task automatic idle();
		int n;
		n = 0;
		repeat (2) @(posedge core_clk_i);
		#1;
		while (cmd_ready_o !== 1'b1 && n < 5000) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		check(8'(cmd_ready_o), 8'h01);
		check(8'(slot_id_o), 8'(SLOT_ID));
		check(8'(busy_o), 8'h00);
		check(8'(slot_line_o), 8'h00);
	endtask

	task automatic write_txn();
		enclosure_model_i.rx_q.delete();
		wr_q = '{8'hA5, 8'h3C};
		start(8'h05, 1'b1, 16'h0002);
		wait_done();
		check(8'(status_o), 8'(STAT_OK));
		cmp_q(enclosure_model_i.rx_q, '{8'h05, 8'h01, 8'h00, 8'h02, 8'hA5, 8'h3C});
		idle();
	endtask

	// Slow enclosure and a stalling receiver on an inbound page
	task automatic read_txn();
		enclosure_model_i.rx_q.delete();
		enclosure_model_i.tx_q = '{8'h11, 8'hE2, 8'h7D};
		enclosure_model_i.dly_ns = 5000;
		rd_q.delete();
		stall = 1'b1;
		start(8'h07, 1'b0, 16'h0003);
		wait_done();
		// The last byte may still sit in the buffer behind a stall
		stall = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1;
		check(8'(status_o), 8'(STAT_OK));
		cmp_q(enclosure_model_i.rx_q, '{8'h07, 8'h00, 8'h00, 8'h00});
		cmp_q(rd_q, '{8'h11, 8'hE2, 8'h7D});
		enclosure_model_i.dly_ns = 200;
		stall = 1'b0;
		idle();
	endtask

	task automatic unmated_txn();
		logic [7:0] exp[$];
		exp = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
		enclosure_model_i.tx_q = exp;
		enclosure_model_i.rx_q.delete();
		rd_q.delete();
		mate_open_i = 2'b11;
		wait_done();
		check(8'(status_o), 8'(STAT_OK));
		cmp_q(enclosure_model_i.rx_q, '{8'h01, 8'h00, 8'h00, 8'h00});
		cmp_q(rd_q, exp);
		mate_open_i = 2'b00;
		idle();
	endtask

	task automatic run_mode(input logic [1:0] m);
		mode = m;
		enclosure_model_i.rx_q.delete();
		wr_q = '{8'h99};
		start(8'h02, 1'b1, 16'h0001);
		wait_done();
		wr_q.delete();
		idle();
	endtask

	initial begin
		do_reset();
		write_txn();
		read_txn();
		unmated_txn();
		enclosure_model_i.dly_ns = 10000;
		run_mode(2'd0);
		check(8'(status_o), 8'(STAT_TIMEOUT));
		enclosure_model_i.dly_ns = 200;
		run_mode(2'd3);
		check(8'(status_o), 8'(STAT_UNAVAILABLE));
		run_mode(2'd2);
		check(8'(status_o), 8'(STAT_LEGACY_NONE));
		do_reset();
		run_mode(2'd1);
		check(8'(status_o), 8'(STAT_LEGACY_PAR));
		check(8'(legacy_status_o), 8'h55);
		run_mode(2'd0);
		check(8'(status_o), 8'(STAT_LEGACY_PAR));
		check(8'(legacy_mode_o), 8'h01);
		check(8'(enclosure_model_i.rx_q.size()), 8'h00);
		complete_run();
	end
endmodule
